/* File: verilog/mfbc_regs.svh */
// register offsets, field positions, reset values and timing counts
// ***********************************************************************
// Summary of operation
// - upper 2T count is limit sum plus half difference, rounded up
// - lower 2T count is limit sum minus half difference
// - single-period window comes from the low and high limit registers
// - from the start bit on, decoded bits fill the buffer byte by byte
// - more than 16 unread bytes overwrite the oldest stored bytes
// - receive counter counts bytes in and bytes read, readable by host
// - receive interrupt when the rising counter hits the threshold
// - level bits pick 4, 8, 12 bytes, or empty or receive error
// - buffer access, config write or delete command clears interrupt
// - a bit error raises interrupt and returns to start-up
// - errors: short, between windows, too long, or no mid-bit edge
// - a byte holding a bit error never enters the buffer
// - config write in receive resets buffer logic and counter
// - receive mode still selected after config write restarts start-up
// - rising transition decodes 1; transparent pin follows the level
// - mode bits 0 and 1 select transmit
// - pattern bit sends buffer bits as NRZ, no Manchester coding
// - transmit waits in start-up until the synthesizer is locked
// - loads taken in start-up or transmit; sends MSB first by itself
// - transmit counter interrupt when the falling count hits threshold
// - config write in transmit clears buffer and counter
// - transparent bit disables the buffer; pin stream is sent
// - Manchester 1 is low to high; pattern or transparent 1 is high
// ***********************************************************************
`ifndef MFBC_REGS_SVH
`define MFBC_REGS_SVH

// ***********************************************************************
// register indices
// ***********************************************************************
`define MFBC_REG_CFG1 4'h1
`define MFBC_REG_CFG4 4'h4
`define MFBC_REG_CFG5 4'h5
`define MFBC_REG_CFG6 4'h6
`define MFBC_REG_DATA 4'h8
`define MFBC_REG_STATUS 4'h9
`define MFBC_REG_CMD 4'ha

// ***********************************************************************
// field positions
// ***********************************************************************
`define MFBC_CFG1_OP_LO 0
`define MFBC_CFG1_OP_HI 1
`define MFBC_CFG1_IRQ_LO 2
`define MFBC_CFG1_IRQ_HI 3
`define MFBC_CFG1_TRANSP 4
`define MFBC_CFG1_PATTERN 5
`define MFBC_CFG4_ASK 0
`define MFBC_CFG4_RATE_RANGE_EXTEND 1
`define MFBC_CMD_DEL_IRQ 0

// ***********************************************************************
// reset values and timing
// ***********************************************************************
`define MFBC_CFG1_RST 8'h00
`define MFBC_CFG4_RST 8'h00
`define MFBC_CFG5_RST 8'h0e
`define MFBC_CFG6_RST 8'h18
`define MFBC_TICK_DIV 100
`define MFBC_DEPTH 16

`endif

/* File: verilog/mfbc_pkg.sv */
// types shared by the codec modules
package mfbc_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_rx_start,
      st_rx_hunt,
      st_rx_data,
      st_tx_start,
      st_tx_active
   } mfbc_state_type;

   typedef enum logic [2:0] {
      iv_short,
      iv_single,
      iv_gap,
      iv_double,
      iv_long
   } mfbc_interval_type;

endpackage

/* File: verilog/mfbc_edge_timer.sv */
// edge-to-edge interval timer and T/2T window classifier
`timescale 1ns/1ps
`default_nettype none
module mfbc_edge_timer
   import mfbc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic level,
   input wire logic restart,
   input wire logic [5:0] lim_min,
   input wire logic [5:0] lim_max,
   output logic edge_seen_q,
   output logic edge_rise_q,
   output logic timeout_q,
   output mfbc_interval_type interval_q
);
   logic [7:0] sum;
   logic [7:0] diff;
   logic [7:0] dbl_low;
   logic [7:0] dbl_high;
   logic [7:0] count_q;
   logic armed_q;
   logic level_q;
   logic edge_now;

   assign sum = {2'h0, lim_min} + {2'h0, lim_max};
   assign diff = {2'h0, lim_max} - {2'h0, lim_min};
   // subtracting the floor of the half rounds the result up
   assign dbl_low = sum - {1'b0, diff[7:1]};
   assign dbl_high = sum + {1'b0, diff[7:1]} + {7'h00, diff[0]};
   assign edge_now = level != level_q;

   always_ff @(posedge clock) begin
      if (sys_rst || restart) begin
         level_q <= level;
         count_q <= 8'h00;
         armed_q <= 1'b0;
      end else begin
         level_q <= level;
         if (edge_now) begin
            count_q <= 8'h00;
            armed_q <= 1'b1;
         end else if (tick && armed_q) begin
            if (count_q + 8'h01 >= dbl_high) begin
               armed_q <= 1'b0;
            end
            if (count_q != 8'hff) begin
               count_q <= count_q + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || restart) begin
         edge_seen_q <= 1'b0;
         edge_rise_q <= 1'b0;
         timeout_q <= 1'b0;
         interval_q <= iv_short;
      end else begin
         edge_seen_q <= edge_now && armed_q;
         edge_rise_q <= level;
         // no edge inside the double window is an error too
         timeout_q <= !edge_now && tick && armed_q &&
            (count_q + 8'h01 >= dbl_high);
         if (count_q < {2'h0, lim_min}) begin
            interval_q <= iv_short;
         end else if (count_q < {2'h0, lim_max}) begin
            interval_q <= iv_single;
         end else if (count_q < dbl_low) begin
            interval_q <= iv_gap;
         end else if (count_q < dbl_high) begin
            interval_q <= iv_double;
         end else begin
            interval_q <= iv_long;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/mfbc_top.sv */
// receive/transmit frame buffer codec with register port
`timescale 1ns/1ps
`default_nettype none
`include "mfbc_regs.svh"
module mfbc_top
   import mfbc_pkg::*;
#(
   parameter int DETECT_DIV = `MFBC_TICK_DIV,
   parameter int DEPTH = `MFBC_DEPTH
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   input wire logic demod_pin,
   input wire logic pll_lock_pin,
   input wire logic serial_in_tx_stream_pin,
   output logic serial_out_rx_stream_pin,
   output logic tx_level_q,
   output logic synth_enable_q,
   output logic irq_q
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   // ********************************************************************
   // synchronisers and detection tick
   // ********************************************************************
   logic [2:0] sync_meta_q;
   logic [2:0] sync_q;
   logic demod_s;
   logic lock_s;
   logic tx_pin_s;
   logic [15:0] div_q;
   logic tick_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_meta_q <= 3'h0;
         sync_q <= 3'h0;
      end else begin
         sync_meta_q <= {serial_in_tx_stream_pin, pll_lock_pin, demod_pin};
         sync_q <= sync_meta_q;
      end
   end
   assign demod_s = sync_q[0];
   assign lock_s = sync_q[1];
   assign tx_pin_s = sync_q[2];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q == 16'(DETECT_DIV - 1)) begin
         div_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // ********************************************************************
   // configuration registers
   // ********************************************************************
   logic [7:0] cfg1_q;
   logic [7:0] cfg4_q;
   logic [7:0] cfg5_q;
   logic [7:0] cfg6_q;
   logic cfg_write;
   logic buf_rd;
   logic buf_wr;
   logic del_cmd;
   logic rx_mode;
   logic tx_mode;
   logic transparent;
   logic pattern;
   logic [1:0] level_sel;

   assign cfg_write = reg_wr && (reg_addr == `MFBC_REG_CFG1 ||
      reg_addr == `MFBC_REG_CFG4 || reg_addr == `MFBC_REG_CFG5 ||
      reg_addr == `MFBC_REG_CFG6);
   assign buf_rd = reg_rd && reg_addr == `MFBC_REG_DATA;
   assign buf_wr = reg_wr && reg_addr == `MFBC_REG_DATA;
   assign del_cmd = reg_wr && reg_addr == `MFBC_REG_CMD &&
      reg_wdata[`MFBC_CMD_DEL_IRQ];
   assign rx_mode = cfg1_q[`MFBC_CFG1_OP_HI] && cfg1_q[`MFBC_CFG1_OP_LO];
   assign tx_mode = !cfg1_q[`MFBC_CFG1_OP_HI] &&
      cfg1_q[`MFBC_CFG1_OP_LO];
   assign transparent = cfg1_q[`MFBC_CFG1_TRANSP];
   assign pattern = cfg1_q[`MFBC_CFG1_PATTERN];
   assign level_sel = {cfg1_q[`MFBC_CFG1_IRQ_HI], cfg1_q[`MFBC_CFG1_IRQ_LO]};

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cfg1_q <= `MFBC_CFG1_RST;
         cfg4_q <= `MFBC_CFG4_RST;
         cfg5_q <= `MFBC_CFG5_RST;
         cfg6_q <= `MFBC_CFG6_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `MFBC_REG_CFG1: cfg1_q <= reg_wdata;
            `MFBC_REG_CFG4: cfg4_q <= reg_wdata;
            `MFBC_REG_CFG5: cfg5_q <= reg_wdata;
            `MFBC_REG_CFG6: cfg6_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ********************************************************************
   // operating state
   // ********************************************************************
   mfbc_state_type state_q;
   logic bit_error;
   logic start_found;
   logic decode_on;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= st_idle;
      end else if (cfg_write) begin
         // idle re-dispatches on the new mode bits
         state_q <= st_idle;
      end else begin
         case (state_q)
            st_idle: begin
               if (rx_mode) begin
                  state_q <= st_rx_start;
               end else if (tx_mode) begin
                  state_q <= st_tx_start;
               end
            end
            st_rx_start: begin
               if (lock_s) begin
                  state_q <= st_rx_hunt;
               end
            end
            st_rx_hunt: begin
               if (bit_error) begin
                  state_q <= st_rx_start;
               end else if (start_found) begin
                  state_q <= st_rx_data;
               end
            end
            st_rx_data: begin
               if (bit_error) begin
                  state_q <= st_rx_start;
               end
            end
            st_tx_start: begin
               if (lock_s) begin
                  state_q <= st_tx_active;
               end
            end
            st_tx_active: ;
            default: state_q <= st_idle;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         synth_enable_q <= 1'b0;
      end else begin
         synth_enable_q <= state_q != st_idle && !cfg_write;
      end
   end

   // ********************************************************************
   // receive decoder
   // ********************************************************************
   logic edge_seen;
   logic edge_rise;
   logic timeout;
   mfbc_interval_type interval;
   logic at_mid_q;
   logic [6:0] shift_q;
   logic [2:0] bitcnt_q;
   logic got_bit;
   logic rx_push;

   assign decode_on = (state_q == st_rx_hunt || state_q == st_rx_data) &&
      !transparent;

   mfbc_edge_timer u_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .tick(tick_q),
      .level(demod_s),
      .restart(!decode_on || bit_error || cfg_write),
      .lim_min(cfg5_q[5:0]),
      .lim_max(cfg6_q[5:0]),
      .edge_seen_q(edge_seen),
      .edge_rise_q(edge_rise),
      .timeout_q(timeout),
      .interval_q(interval)
   );

   // preamble edges are all T apart; the first 2T is the start bit's
   // mid-bit edge, which only works if the start bit breaks the pattern
   assign start_found = decode_on && state_q == st_rx_hunt && edge_seen &&
      interval == iv_double;
   assign bit_error = decode_on && (timeout || (edge_seen &&
      (interval == iv_short || interval == iv_gap || interval == iv_long ||
      (state_q == st_rx_data && interval == iv_double &&
      !at_mid_q))));
   assign got_bit = decode_on && edge_seen && !bit_error &&
      (start_found || (state_q == st_rx_data &&
      (interval == iv_double || !at_mid_q)));
   assign rx_push = got_bit && bitcnt_q == 3'h7;

   always_ff @(posedge clock) begin
      if (sys_rst || !decode_on || bit_error || cfg_write) begin
         // a partial byte is dropped here on error
         at_mid_q <= 1'b0;
         shift_q <= 7'h00;
         bitcnt_q <= 3'h0;
      end else if (edge_seen) begin
         at_mid_q <= got_bit;
         if (got_bit) begin
            // rising mid-bit edge is a one
            shift_q <= {shift_q[5:0], edge_rise};
            bitcnt_q <= bitcnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         serial_out_rx_stream_pin <= 1'b0;
      end else begin
         serial_out_rx_stream_pin <= rx_mode && transparent &&
            (state_q == st_rx_hunt || state_q == st_rx_data) &&
            demod_s;
      end
   end

   // ********************************************************************
   // data buffer and byte counter
   // ********************************************************************
   logic [7:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [7:0] push_data;
   logic push;
   logic pop;
   logic full;
   logic tx_load;
   logic host_load;

   assign full = cnt_q == CW'(DEPTH);
   assign host_load = buf_wr && !transparent &&
      (state_q == st_tx_start || state_q == st_tx_active);
   assign push = rx_push || host_load;
   assign push_data = rx_push ? {shift_q, edge_rise} : reg_wdata;
   assign pop = tx_load || (buf_rd && cnt_q != '0 &&
      (state_q == st_rx_hunt || state_q == st_rx_data));

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop && !full) begin
         cnt_d = cnt_q + CW'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - CW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_ptr_q] <= push_data;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || cfg_write) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         if (push) begin
            wr_ptr_q <= wr_ptr_q + PW'(1);
         end
         // a push into a full buffer drops the oldest byte
         if (pop || (push && full)) begin
            rd_ptr_q <= rd_ptr_q + PW'(1);
         end
      end
   end

   // ********************************************************************
   // buffer interrupt
   // ********************************************************************
   function automatic logic [CW-1:0] level_threshold(input logic [1:0] sel);
      case (sel)
         2'h0: level_threshold = CW'(4);
         2'h1: level_threshold = CW'(8);
         2'h2: level_threshold = CW'(12);
         default: level_threshold = '0;
      endcase
   endfunction

   logic irq_set;
   logic irq_clr;
   logic [CW-1:0] threshold;

   assign threshold = level_threshold(level_sel);
   assign irq_set = bit_error ||
      (rx_push && cnt_d != cnt_q && cnt_d == threshold) ||
      (tx_load && !push && cnt_d == threshold);
   assign irq_clr = buf_rd || buf_wr || cfg_write || del_cmd;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else if (irq_set && !buf_rd && !cfg_write) begin
         // a read in progress masks new buffer events
         irq_q <= 1'b1;
      end else if (irq_clr) begin
         irq_q <= 1'b0;
      end
   end

   // ********************************************************************
   // transmit serialiser
   // ********************************************************************
   logic busy_q;
   logic [7:0] byte_q;
   logic [2:0] bitidx_q;
   logic half_q;
   logic [6:0] hcnt_q;
   logic [6:0] half_len;
   logic cur_bit;
   logic symbol;

   // half-bit length in ticks follows the low limit, doubled by the
   // range-extension bit
   assign half_len = cfg4_q[`MFBC_CFG4_RATE_RANGE_EXTEND] ? {cfg5_q[5:0], 1'b0} :
      {1'b0, cfg5_q[5:0]};
   assign tx_load = state_q == st_tx_active && !transparent && !busy_q &&
      cnt_q != '0 && !cfg_write;
   assign cur_bit = byte_q[bitidx_q];
   // manchester: inverted first half, true second half
   assign symbol = pattern ? cur_bit :
      (half_q ? cur_bit : !cur_bit);

   always_ff @(posedge clock) begin
      if (sys_rst || cfg_write || state_q != st_tx_active) begin
         busy_q <= 1'b0;
         byte_q <= 8'h00;
         bitidx_q <= 3'h7;
         half_q <= 1'b0;
         hcnt_q <= 7'h00;
      end else if (tx_load) begin
         busy_q <= 1'b1;
         byte_q <= mem_q[rd_ptr_q];
         bitidx_q <= 3'h7;
         half_q <= 1'b0;
         hcnt_q <= 7'h00;
      end else if (busy_q && tick_q) begin
         if (hcnt_q + 7'h01 >= half_len) begin
            hcnt_q <= 7'h00;
            half_q <= !half_q;
            if (half_q) begin
               if (bitidx_q == 3'h0) begin
                  busy_q <= 1'b0;
               end
               bitidx_q <= bitidx_q - 3'h1;
            end
         end else begin
            hcnt_q <= hcnt_q + 7'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tx_level_q <= 1'b0;
      end else if (state_q == st_tx_active && transparent) begin
         tx_level_q <= tx_pin_s;
      end else if (busy_q) begin
         tx_level_q <= symbol;
      end else begin
         tx_level_q <= 1'b0;
      end
   end

   // ********************************************************************
   // register read port
   // ********************************************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `MFBC_REG_CFG1: reg_rdata_q <= cfg1_q;
            `MFBC_REG_CFG4: reg_rdata_q <= cfg4_q;
            `MFBC_REG_CFG5: reg_rdata_q <= cfg5_q;
            `MFBC_REG_CFG6: reg_rdata_q <= cfg6_q;
            `MFBC_REG_DATA: reg_rdata_q <= cnt_q != '0 ?
               mem_q[rd_ptr_q] : 8'h00;
            `MFBC_REG_STATUS: reg_rdata_q <= {decode_on, lock_s, irq_q,
               cnt_q};
            default: reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: verif/mfbc_top_monitor.sv */
// port-level assertion checker for the codec top
`timescale 1ns/1ps
`default_nettype none
`include "mfbc_regs.svh"
module mfbc_top_monitor #(
   parameter int DETECT_DIV = 100,
   parameter int DEPTH = 16
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic pll_lock_pin,
   input wire logic tx_level_q,
   input wire logic synth_enable_q,
   input wire logic irq_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire cfg_w = reg_wr && reg_addr inside {4'h1, 4'h4, 4'h5, 4'h6};
   sequence cfg_wr_s;
      cfg_w;
   endsequence
   sequence stat_rd_s;
      reg_rd && reg_addr == `MFBC_REG_STATUS;
   endsequence
   cfg_clear_a: assert property (cfg_wr_s |=> !irq_q)
      else $error("irq survived a config write");
   rd_clear_a: assert property (
      reg_rd && reg_addr == `MFBC_REG_DATA |=> !irq_q)
      else $error("irq survived a data read");
   reset_clear_a: assert property (disable iff (1'b0)
      sys_rst |=> !irq_q && !synth_enable_q && !tx_level_q)
      else $error("outputs not quiet after reset");
   count_max_a: assert property (
      stat_rd_s |=> reg_rdata_q[4:0] <= DEPTH)
      else $error("count above depth");
   cfg_count_a: assert property (
      cfg_wr_s ##1 !reg_wr ##[0:1] stat_rd_s |=> reg_rdata_q[4:0] == 5'h00)
      else $error("count kept after config write");
   tx_enter_a: assert property (
      reg_wr && reg_addr == `MFBC_REG_CFG1 && reg_wdata[1:0] == 2'b01
      |-> ##[1:4] synth_enable_q) else $error("no start-up for tx");
   lock_wait_a: assert property (
      ($rose(synth_enable_q) && !pll_lock_pin) ##1 (!pll_lock_pin)[*8]
      |-> !tx_level_q) else $error("sending without lock");
   idle_quiet_a: assert property (
      !synth_enable_q && !$past(synth_enable_q) |-> !tx_level_q)
      else $error("modulation while idle");
endmodule
bind mfbc_top mfbc_top_monitor #(.DETECT_DIV(DETECT_DIV), .DEPTH(DEPTH))
   mfbc_top_monitor_i (.clock(clock), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pll_lock_pin(pll_lock_pin),
   .tx_level_q(tx_level_q), .synth_enable_q(synth_enable_q), .irq_q(irq_q));
`default_nettype wire

/* File: verif/mfbc_sender.sv */
// far-side transmitter model producing the demodulated manchester stream
`timescale 1ns/1ps
`default_nettype none
module mfbc_sender #(
   parameter int HALF = 36
)(
   input wire logic clock,
   output logic demod_pin
);
   initial demod_pin = 1'b0;
   // level 1 is carrier on; a 1 is a rising mid-bit edge
   task send_bit(input logic b);
      @(posedge clock);
      demod_pin <= ~b;
      repeat (HALF) @(posedge clock);
      demod_pin <= b;
      repeat (HALF - 1) @(posedge clock);
   endtask
   // stream simply stops after the last bit, as a real burst would
   task frame(input logic [23:0] d, input int n);
      repeat (4) send_bit(1'b0);
      for (int i = 0; i < n; i++) begin
         send_bit(d[23 - i]);
      end
   endtask
endmodule
`default_nettype wire

/* File: verif/mfbc_top_test.sv */
// self-checking testbench for the frame buffer codec
`timescale 1ns/1ps
`default_nettype none
`include "mfbc_regs.svh"
module mfbc_top_test;
   logic clock, sys_rst, reg_wr, reg_rd, pll_lock_pin, ser_in;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_q, rv;
   logic demod_pin, rx_out, tx_level_q, synth_enable_q, irq_q;
   int miscompares = 0, num_checks = 0;
   // short tick keeps frames brief: T is 18 ticks of 2 clocks
   mfbc_top #(.DETECT_DIV(2), .DEPTH(16)) mfbc_top_i (.clock(clock),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .demod_pin(demod_pin), .pll_lock_pin(pll_lock_pin),
      .serial_in_tx_stream_pin(ser_in), .serial_out_rx_stream_pin(rx_out),
      .tx_level_q(tx_level_q), .synth_enable_q(synth_enable_q),
      .irq_q(irq_q));
   mfbc_sender #(.HALF(36)) mfbc_sender_i (.clock(clock),
      .demod_pin(demod_pin));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task chk(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", what, e, g);
         miscompares++;
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task expire(input int i, input int lim);
      if (i >= lim) begin
         miscompares++;
         close_out();
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata_q;
   endtask
   task test_reset;
      rd(`MFBC_REG_CFG5, rv);
      chk("cfg5", `MFBC_CFG5_RST, rv);
      rd(`MFBC_REG_CFG6, rv);
      chk("cfg6", `MFBC_CFG6_RST, rv);
      rd(4'hf, rv);
      chk("unmapped", 8'h00, rv);
      rd(`MFBC_REG_STATUS, rv);
      chk("count irq", 8'h00, {3'h0, rv[4:0]} | {7'h0, irq_q});
      $display("reset test done");
   endtask
   task test_rx;
      int i;
      wr(`MFBC_REG_CFG1, 8'h03);
      mfbc_sender_i.frame(24'hb53ca0, 19);
      i = 0;
      while (irq_q !== 1'b1 && i < 4000) begin
         @(negedge clock);
         i++;
      end
      expire(i, 4000);
      rd(`MFBC_REG_STATUS, rv);
      chk("rx count", 8'h02, {3'h0, rv[4:0]});
      rd(`MFBC_REG_DATA, rv);
      chk("rx byte", 8'hb5, rv);
      chk("irq after read", 8'h00, {7'h0, irq_q});
      wr(`MFBC_REG_CFG5, 8'h0e);
      rd(`MFBC_REG_STATUS, rv);
      chk("count after cfg", 8'h00, {3'h0, rv[4:0]});
      chk("restart", 8'h01, {7'h0, synth_enable_q});
      $display("rx test done");
   endtask
   task test_tx(input logic [7:0] cfg, input logic [7:0] b,
                input logic pat, input logic eirq);
      int i;
      logic eb;
      @(posedge clock);
      pll_lock_pin <= 1'b0;
      wr(`MFBC_REG_CFG5, 8'h0e);
      wr(`MFBC_REG_CFG1, cfg);
      wr(`MFBC_REG_DATA, b);
      repeat (40) @(negedge clock);
      chk("lock wait", 8'h02, {6'h0, synth_enable_q, tx_level_q});
      @(posedge clock);
      pll_lock_pin <= 1'b1;
      i = 0;
      while (tx_level_q !== 1'b1 && i < 200) begin
         @(negedge clock);
         i++;
      end
      expire(i, 200);
      repeat (14) @(negedge clock);
      for (i = 0; i < 16; i++) begin
         eb = b[7 - i / 2];
         chk("tx half", {7'h0, (pat || i[0]) ? eb : ~eb},
             {7'h0, tx_level_q});
         repeat (28) @(negedge clock);
      end
      chk("tx irq", {7'h0, eirq}, {7'h0, irq_q});
      wr(`MFBC_REG_CMD, 8'h01);
      @(negedge clock);
      chk("irq deleted", 8'h00, {7'h0, irq_q});
      $display("tx test done");
   endtask
   task test_transp;
      wr(`MFBC_REG_CFG1, 8'h11);
      wr(`MFBC_REG_DATA, 8'hff);
      rd(`MFBC_REG_STATUS, rv);
      chk("no buffer", 8'h00, {3'h0, rv[4:0]});
      @(posedge clock);
      ser_in <= 1'b1;
      repeat (6) @(negedge clock);
      chk("pin high", 8'h01, {6'h0, rx_out, tx_level_q});
      @(posedge clock);
      ser_in <= 1'b0;
      repeat (6) @(negedge clock);
      chk("pin low", 8'h00, {7'h0, tx_level_q});
      // receive side in transparent mode: pin follows the demodulated level
      wr(`MFBC_REG_CFG1, 8'h13);
      mfbc_sender_i.send_bit(1'b1);
      @(negedge clock);
      chk("rx pin high", 8'h01, {7'h0, rx_out});
      mfbc_sender_i.send_bit(1'b0);
      @(negedge clock);
      chk("rx pin low", 8'h00, {7'h0, rx_out});
      $display("transparent test done");
   endtask
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      pll_lock_pin = 1'b0;
      ser_in = 1'b0;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      test_reset();
      @(posedge clock);
      pll_lock_pin <= 1'b1;
      test_rx();
      test_tx(8'h01, 8'h5a, 1'b0, 1'b0);
      test_tx(8'h2d, 8'ha5, 1'b1, 1'b1);
      test_transp();
      close_out();
   end
endmodule
`default_nettype wire
